// ===== design/sdm_cfg.svh
// Register map, field positions and reset values of the demodulator configuration block
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// Byte addresses on the register port
`define SDM_ADDR_CFG   8'h70
`define SDM_ADDR_STAT  8'h74
`define SDM_ADDR_MASK  8'h78

// Field positions of signal_conditioning_config
`define SDM_POL_BIT    26
`define SDM_AA_HI      25
`define SDM_AA_LO      24
`define SDM_SUBS_HI    20
`define SDM_SUBS_LO    13
`define SDM_LP_HI      12
`define SDM_LP_LO      11

// Reset value and writable bits of signal_conditioning_config
`define SDM_CFG_RST    32'h0000_0000
`define SDM_CFG_WMASK  32'h071f_f800

// Event bits of the status and mask registers
`define SDM_EV_W       3
`define SDM_EV_CONV    0
`define SDM_EV_START   1
`define SDM_EV_STOP    2

// Anti-aliasing codes and the corner each selects, in kHz
`define SDM_AA_10K     2'h0
`define SDM_AA_20K     2'h1
`define SDM_AA_40K     2'h2
`define SDM_AA_60K     2'h3
`define SDM_KHZ_10     7'h0a
`define SDM_KHZ_20     7'h14
`define SDM_KHZ_40     7'h28
`define SDM_KHZ_60     7'h3c

`endif

// ===== design/sdm_pkg.sv
// Types shared by the demodulator configuration block
package sdm_pkg;

  // Demodulator activity, one-hot
  typedef enum logic [1:0] {
    DM_IDLE = 2'b01,
    DM_RUN  = 2'b10
  } demod_state_t;

  // Multiplier setting: inactive is 0, else +1 or -1
  typedef struct packed {
    logic active;
    logic negative;
  } demod_mult_t;

  // Whole state of the top module except its reset pipe and the subsample_gate instance
  typedef struct packed {
    logic [31:0]  cfg;
    logic [31:0]  rdata;
    logic [2:0]   stat;
    logic [2:0]   mask;
    demod_state_t st;
    logic         pol_cur;
    logic         win;
    demod_mult_t  dm;
  } top_state_t;

endpackage

// ===== design/subsample_gate.sv
// Iteration counter that picks the sequencer iterations carrying an ADC conversion
`timescale 1ns/10ps
`default_nettype none

module subsample_gate #(
  parameter int RATIO_W = 8
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_sync_n,
  input  wire logic               clear,
  input  wire logic               iter,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    fire
);

  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic               fire;
  } gate_state_t;

  gate_state_t q;
  gate_state_t d;

  // Ratio must fit a sane counter
  if (RATIO_W < 1 || RATIO_W > 16) begin : g_bad_width
    $error("subsample_gate: RATIO_W must be 1 to 16");
  end

  // Count skipped iterations; fire on the one after ratio skips
  always_comb begin
    logic [RATIO_W-1:0] base;
    base = q.cnt;
    d = q;
    d.fire = 1'b0;
    // R9: restart clears count
    if (clear) begin
      base = '0;
    end
    d.cnt = base;
    // R5: skip then convert
    if (iter) begin
      // R4: ratio zero fires always
      // A ratio lowered below the count fires at once instead of waiting for a wrap
      if (base >= ratio) begin
        d.cnt = '0;
        d.fire = 1'b1;
      end else begin
        d.cnt = base + {{(RATIO_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fire = q.fire;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  skip_no_fire_a: assert property ( // R5
    (iter && !clear && q.cnt < ratio) |=> !fire)
    else $error("conversion fired before the skip count ran out");

  last_skip_fires_a: assert property ( // R5
    (iter && !clear && q.cnt >= ratio) |=> fire ##1 (!fire || $past(iter)))
    else $error("conversion missing after the skip count");

  start_clears_a: assert property ( // R9
    (clear && !iter) |=> (q.cnt == '0) && !fire)
    else $error("sequence start did not clear the skip counter");

  cover_skipped_fire: cover property (
    (ratio != '0) && iter && (q.cnt == ratio) ##1 fire);

endmodule

`default_nettype wire

// ===== design/signal_conditioning_regs.sv
// Configuration register, subsampling and demodulator control of the optical path
//
// Summary of operation
// R1: Software writes the initial polarity as 0 when a negative window leads and 1 when positive.
// R2: The two-bit anti-aliasing code selects 10, 20, 40 or 60 kHz for codes 0 to 3.
// R3: The ADC rate is the iteration rate divided by the subsampling value plus one.
// R4: A subsampling value of zero converts in every sequencer iteration.
// R5: A value N gives N iterations with no conversion, then one with a conversion, repeating.
// R6: Software should rely on the ADC completion interrupt while subsampling is active.
// R7: Software must enable the signal reference before the optical path can work.
// R8: The demodulator multiplies by +1, 0 or -1 on sequencer windows, only while it runs.
// R9: The skip counter is cleared when the sequencer starts.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "sdm_cfg.svh"

module signal_conditioning_regs (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  input  wire logic         seq_start,
  input  wire logic         seq_running,
  input  wire logic         seq_iter,
  input  wire logic         seq_window,
  output logic              adc_trigger,
  output sdm_pkg::demod_mult_t demod_mult,
  output logic              demod_initial_polarity,
  output logic [1:0]        antialias_cutoff_select,
  output logic [6:0]        antialias_cutoff_khz,
  output logic [1:0]        demod_lowpass_select,
  output logic [7:0]        demod_subsample_ratio,
  output logic              irq
);

  localparam int SUBS_W = `SDM_SUBS_HI - `SDM_SUBS_LO + 1;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------

  // Reset asserts at once and releases two edges later
  logic [1:0] rst_pipe_q;
  logic       rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_q[1];

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------

  // Filter corner for an anti-aliasing code
  function automatic logic [6:0] aa_khz(input logic [1:0] code);
    logic [6:0] khz;
    case (code)
      `SDM_AA_10K: khz = `SDM_KHZ_10;
      `SDM_AA_20K: khz = `SDM_KHZ_20;
      `SDM_AA_40K: khz = `SDM_KHZ_40;
      `SDM_AA_60K: khz = `SDM_KHZ_60;
      default:     khz = `SDM_KHZ_10;
    endcase
    return khz;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  sdm_pkg::top_state_t q;
  sdm_pkg::top_state_t d;
  logic                conv_fire;
  logic [2:0]          events;
  logic [2:0]          clr;
  logic                seq_stop;

  // Sequencer stopping while the demodulator runs
  assign seq_stop = (q.st == sdm_pkg::DM_RUN) && !seq_running;

  // Events that raise sticky status bits
  always_comb begin
    events = '0;
    events[`SDM_EV_CONV] = conv_fire;
    events[`SDM_EV_START] = seq_start;
    events[`SDM_EV_STOP] = seq_stop;
  end

  // Bits written as one clear their status bit
  assign clr = (reg_wr && reg_addr == `SDM_ADDR_STAT) ? reg_wdata[`SDM_EV_W-1:0] : '0;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  always_comb begin
    d = q;

    // Read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `SDM_ADDR_CFG:  d.rdata = q.cfg;
        `SDM_ADDR_STAT: d.rdata = 32'(q.stat);
        `SDM_ADDR_MASK: d.rdata = 32'(q.mask);
        default:        d.rdata = '0;
      endcase
    end

    // Only the fields this block owns are writable; others read zero
    if (reg_wr) begin
      case (reg_addr)
        `SDM_ADDR_CFG:  d.cfg = reg_wdata & `SDM_CFG_WMASK;
        `SDM_ADDR_MASK: d.mask = reg_wdata[`SDM_EV_W-1:0];
        default:        d.cfg = q.cfg;
      endcase
    end

    // Set beats clear so an event in the clearing cycle survives
    d.stat = (q.stat & ~clr) | events;

    // Demodulator activity follows the sequencer
    d.win = seq_window;
    case (q.st)
      sdm_pkg::DM_IDLE: begin
        if (seq_start) begin
          d.st = sdm_pkg::DM_RUN;
          d.pol_cur = q.cfg[`SDM_POL_BIT];
        end
      end
      sdm_pkg::DM_RUN: begin
        if (!seq_running) begin
          d.st = sdm_pkg::DM_IDLE;
        end else if (seq_start) begin
          d.pol_cur = q.cfg[`SDM_POL_BIT];
        end else if (q.win && !seq_window) begin
          // Windows alternate sign, so each closing window flips it
          d.pol_cur = !q.pol_cur;
        end
      end
      default: begin
        d.st = sdm_pkg::DM_IDLE;
        d.pol_cur = 1'b0;
      end
    endcase

    // R8: multiply by +1, 0 or -1
    d.dm.active = (d.st == sdm_pkg::DM_RUN) && seq_running && seq_window;
    d.dm.negative = d.dm.active && !d.pol_cur;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q.cfg <= `SDM_CFG_RST;
      q.rdata <= '0;
      q.stat <= '0;
      q.mask <= '0;
      q.st <= sdm_pkg::DM_IDLE;
      q.pol_cur <= 1'b0;
      q.win <= 1'b0;
      q.dm <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Subsampling
  // ---------------------------------------------------------------

  // R3: iteration rate over ratio plus one
  subsample_gate #(
    .RATIO_W (SUBS_W)
  ) u_gate (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .clear      (seq_start),
    .iter       (seq_iter && seq_running),
    .ratio      (q.cfg[`SDM_SUBS_HI:`SDM_SUBS_LO]),
    .fire       (conv_fire)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign reg_rdata = q.rdata;
  assign adc_trigger = conv_fire;
  assign demod_mult = q.dm;
  assign demod_initial_polarity = q.cfg[`SDM_POL_BIT];
  assign antialias_cutoff_select = q.cfg[`SDM_AA_HI:`SDM_AA_LO];
  assign demod_lowpass_select = q.cfg[`SDM_LP_HI:`SDM_LP_LO];
  assign demod_subsample_ratio = q.cfg[`SDM_SUBS_HI:`SDM_SUBS_LO];
  // R2: corner from the code
  assign antialias_cutoff_khz = aa_khz(q.cfg[`SDM_AA_HI:`SDM_AA_LO]);
  // Level interrupt; a late clear cannot lose an event
  assign irq = |(q.stat & q.mask);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  aa_corner_map_a: assert property ( // R2
    antialias_cutoff_khz ==
      (antialias_cutoff_select == `SDM_AA_10K ? `SDM_KHZ_10 :
       antialias_cutoff_select == `SDM_AA_20K ? `SDM_KHZ_20 :
       antialias_cutoff_select == `SDM_AA_40K ? `SDM_KHZ_40 : `SDM_KHZ_60))
    else $error("anti-aliasing corner does not match its code");

  ratio_write_a: assert property ( // R3
    (reg_wr && reg_addr == `SDM_ADDR_CFG)
      |=> demod_subsample_ratio == $past(reg_wdata[`SDM_SUBS_HI:`SDM_SUBS_LO]))
    else $error("subsampling ratio not taken from the write");

  every_iter_a: assert property ( // R4
    (demod_subsample_ratio == 8'h00 && seq_iter && seq_running && !reg_wr)
      |=> adc_trigger)
    else $error("iteration without conversion at ratio zero");

  no_idle_trigger_a: assert property ( // R3
    !$past(seq_iter && seq_running) |-> !adc_trigger)
    else $error("conversion outside a running iteration");

  demod_idle_zero_a: assert property ( // R8
    !$past(seq_running) |-> !demod_mult.active)
    else $error("demodulator active with the sequencer stopped");

  start_polarity_a: assert property ( // R8
    (q.st == sdm_pkg::DM_IDLE && seq_start && seq_running && seq_window)
      |=> demod_mult.active && (demod_mult.negative == !$past(q.cfg[`SDM_POL_BIT])))
    else $error("first window sign differs from the initial polarity");

  sticky_event_a: assert property (
    (seq_start && reg_wr && reg_addr == `SDM_ADDR_STAT && reg_wdata[`SDM_EV_START])
      |=> q.stat[`SDM_EV_START] ##1 (q.stat[`SDM_EV_START] || $past(reg_wr)))
    else $error("start event lost against a clear");

  // ---------------------------------------------------------------
  // Register port and event checks
  // ---------------------------------------------------------------

  // Read data must not linger past their one cycle
  rdata_idle_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data present without a read");

  stat_read_a: assert property (
    (reg_rd && reg_addr == `SDM_ADDR_STAT)
      |=> reg_rdata == 32'($past(q.stat)))
    else $error("status read does not return the status bits");

  mask_write_a: assert property (
    (reg_wr && reg_addr == `SDM_ADDR_MASK)
      |=> q.mask == $past(reg_wdata[`SDM_EV_W-1:0]))
    else $error("mask register not taken from the write");

  reserved_zero_a: assert property (
    (q.cfg & ~`SDM_CFG_WMASK) == '0)
    else $error("bits outside the owned fields were stored");

  // Set must win over a clear in the same cycle
  conv_event_a: assert property ( // R5
    adc_trigger |=> q.stat[`SDM_EV_CONV])
    else $error("conversion did not set its status bit");

  start_event_a: assert property (
    seq_start |=> q.stat[`SDM_EV_START])
    else $error("sequence start did not set its status bit");

  stop_clear_a: assert property (
    (reg_wr && reg_addr == `SDM_ADDR_STAT && reg_wdata[`SDM_EV_STOP] && !seq_stop)
      |=> !q.stat[`SDM_EV_STOP])
    else $error("write of one did not clear the stop bit");

  // ---------------------------------------------------------------
  // Demodulator sign and activity checks
  // ---------------------------------------------------------------

  // A closing window hands the sign over to the next window
  polarity_flip_a: assert property ( // R8
    (q.st == sdm_pkg::DM_RUN && seq_running && !seq_start && q.win && !seq_window)
      |=> q.pol_cur != $past(q.pol_cur))
    else $error("window sign did not alternate");

  stop_idle_a: assert property ( // R8
    (q.st == sdm_pkg::DM_RUN && !seq_running) |=> q.st == sdm_pkg::DM_IDLE)
    else $error("demodulator kept running after the sequencer stopped");

  cover_flip: cover property (q.st == sdm_pkg::DM_RUN && q.win && !seq_window);

  cover_conversion: cover property (seq_iter && seq_running ##1 adc_trigger);
  cover_negative: cover property (demod_mult.active && demod_mult.negative);
  cover_irq: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// ===== dv/test_signal_conditioning_regs.sv
// Self-checking bench for the demodulator configuration and subsampling block
`timescale 1ns/10ps
`default_nettype none
`include "sdm_cfg.svh"

// Counts one comparison and reports a mismatch at once
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin fail_count++; \
  $display("Error %0t: mismatch, got %h expected %h", $time, act, exp); end end

module test_signal_conditioning_regs;
  logic                 clk_sys;
  logic                 rst_n;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic                 seq_start;
  logic                 seq_running;
  logic                 seq_iter;
  logic                 seq_window;
  logic                 adc_trigger;
  sdm_pkg::demod_mult_t demod_mult;
  logic                 pol;
  logic [1:0]           aa_sel;
  logic [6:0]           aa_khz;
  logic [1:0]           lp_sel;
  logic [7:0]           ratio;
  logic                 irq;
  int                   fail_count;
  int                   cmp_count;
  int                   cycles;

  signal_conditioning_regs DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_start(seq_start),
    .seq_running(seq_running), .seq_iter(seq_iter), .seq_window(seq_window),
    .adc_trigger(adc_trigger), .demod_mult(demod_mult), .demod_initial_polarity(pol),
    .antialias_cutoff_select(aa_sel), .antialias_cutoff_khz(aa_khz),
    .demod_lowpass_select(lp_sel), .demod_subsample_ratio(ratio), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, and a ceiling well above the 1200 or so cycles used
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and sequencer helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rdc(logic [7:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, exp)
  endtask

  task automatic start_seq();
    @(posedge clk_sys);
    seq_start <= 1'b1; seq_running <= 1'b1;
    @(posedge clk_sys);
    seq_start <= 1'b0;
  endtask

  // One iteration pulse; the trigger answers exactly one cycle later
  task automatic it(logic exp);
    @(posedge clk_sys);
    seq_iter <= 1'b1;
    @(posedge clk_sys);
    seq_iter <= 1'b0;
    #1 `CHK(adc_trigger, exp)
  endtask

  // One extra iteration leaves a stale count of one behind, for n above zero, to show that start clears it
  task automatic run_subs(int n);
    wr(`SDM_ADDR_CFG, 32'(n) << `SDM_SUBS_LO);
    `CHK(ratio, 8'(n)) // field
    start_seq();
    for (int i = 0; i < 2 * (n + 1); i++) it(i % (n + 1) == n);
    it(n == 0);
    $display("done: subsample %0d", n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fields();
    logic [6:0] khz [4] = '{`SDM_KHZ_10, `SDM_KHZ_20, `SDM_KHZ_40, `SDM_KHZ_60};
    rdc(`SDM_ADDR_CFG, `SDM_CFG_RST);
    wr(`SDM_ADDR_CFG, 32'hffff_ffff);
    rdc(`SDM_ADDR_CFG, `SDM_CFG_WMASK);
    `CHK({pol, aa_sel, lp_sel, ratio}, 13'h1fff)
    rdc(8'h7c, 32'h0000_0000);
    wr(8'h7c, 32'h0000_0000);
    rdc(`SDM_ADDR_CFG, `SDM_CFG_WMASK);
    for (int c = 0; c < 4; c++) begin
      wr(`SDM_ADDR_CFG, 32'(c) << `SDM_AA_LO);
      `CHK(khz[c], aa_khz)
    end
    $display("done: fields");
  endtask

  // Windows alternate sign, starting from the programmed polarity
  task automatic t_demod();
    seq_running <= 1'b0;
    wr(`SDM_ADDR_CFG, 32'h1 << `SDM_POL_BIT); // positive window leads
    start_seq();
    seq_window <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(demod_mult, 2'b10)
    seq_window <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(demod_mult, 2'b00)
    seq_window <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(demod_mult, 2'b11)
    seq_running <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK(demod_mult, 2'b00)
    seq_window <= 1'b0;
    $display("done: demodulator");
  endtask

  task automatic t_irq();
    wr(`SDM_ADDR_STAT, 32'h7);
    wr(`SDM_ADDR_MASK, 32'h0);
    run_subs(0);
    `CHK(irq, 1'b0)
    rdc(`SDM_ADDR_STAT, 32'h3);
    wr(`SDM_ADDR_MASK, 32'h1); // conversion interrupt unmasked
    `CHK(irq, 1'b1)
    wr(`SDM_ADDR_STAT, 32'h1);
    `CHK(irq, 1'b0)
    seq_running <= 1'b0;
    it(1'b0); // ignored when stopped
    rdc(`SDM_ADDR_STAT, 32'h6);
    rdc(`SDM_ADDR_MASK, 32'h1);
    // Start and its clear in one cycle: the start bit must survive
    @(posedge clk_sys);
    seq_start <= 1'b1; seq_running <= 1'b1;
    reg_wr <= 1'b1; reg_addr <= `SDM_ADDR_STAT; reg_wdata <= 32'h2;
    @(posedge clk_sys);
    seq_start <= 1'b0; reg_wr <= 1'b0;
    rdc(`SDM_ADDR_STAT, 32'h6);
    `CHK(irq, 1'b0)
    $display("done: interrupt");
  endtask

  // Lowering the ratio below a stale count must not wait for a wrap
  task automatic t_lower();
    wr(`SDM_ADDR_CFG, `SDM_CFG_RST);
    it(1'b1);
    $display("done: ratio lowered");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    seq_start = 1'b0; seq_running = 1'b0; seq_iter = 1'b0; seq_window = 1'b0;
    fail_count = 0; cmp_count = 0; cycles = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // the reference enable lives in light_emitter_config, taken as set here
    #1 `CHK({adc_trigger, irq, demod_mult, reg_rdata}, 36'h0)
    t_fields();
    t_irq();
    run_subs(1);
    run_subs(3);
    run_subs(3);
    run_subs(255);
    t_lower();
    t_demod();
    stop_test();
  end
endmodule

`default_nettype wire
